// *** rtl/scc_top.sv ***
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module scc_top (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	// Avalon-MM slave
	input  wire logic [7:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	output logic                    irq,
	// Command path
	input  wire logic signed [15:0] analog_in,
	input  wire logic signed [23:0] pos_err_half,
	input  wire logic signed [15:0] vel_cmd_in,
	input  wire logic [1:0]         ctrl_mode,
	output logic signed [15:0]      vel_cmd_out,
	output logic signed [15:0]      op_cmd_out,
	// Stop sources
	input  wire logic               servo_on,
	input  wire logic               overtravel,
	input  wire logic               halt_input,
	// Motion and position scale
	input  wire logic               motor_step,
	input  wire logic               motor_cw,
	output logic [31:0]             position_scale,
	output logic                    fb_a,
	output logic                    fb_b,
	// Ready character to the serial transmitter
	input  wire logic               motion_done,
	input  wire logic               line_edit_busy,
	input  wire logic               tx_ready,
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	// Monitored signals
	input  wire logic               alarm_clear_input,
	input  wire logic               jog_sense_input,
	input  wire logic               estop_input,
	input  wire logic               in_operation_raw,
	input  wire logic               driver_ok_output
);
	import scc_pkg::*;

	// Register map, as software sees it
	// Deadzone word: analog dead zone in the low field, signed counts
	// Deadzone word: position dead zone in the upper field, half pulses
	// Config word: scale sense, feedback phase order, notify, analog enable
	// Override word: signed serial command, read back sign-extended
	// Status word: sticky events, write a one to clear a bit
	// Mask word: same layout as status, selects what raises irq
	// Monitor word: five raw monitor bits, read only
	// Halt word: writing bit 0 high issues a motion halt
	// Position word: the position scale, read only
	// Unmapped offsets ignore writes and read as zero
	//
	// Bus timing
	// Every access takes two cycles: waitrequest is high in the first
	// The write lands at the first edge, where waitrequest is still high
	// Read data are captured at the first edge, so they stand in the second
	// A fixed single wait state keeps the slave free of address decode paths
	// Byte enables are not used; every access is a full word
	// A frozen clock enable also freezes the answer, so the master waits
	//
	// Override handling
	// The override is only taken while the analog path is off
	// While the analog path is on, a write is dropped and flagged
	// The refusal flag is the only inhibit message this block can give
	// Stop sources are levels: while one stands, the override stays zero
	// A write in the same cycle as a stop is lost on purpose
	// The cleared event only counts when a nonzero value was lost
	// Values below the lower limit are clamped, never wrapped
	//
	// Interrupts
	// A fresh event wins over a write-one clear in the same cycle
	// irq is a plain level: status ANDed with mask, bits ORed together
	// Software must clear status before it can see the next edge of irq

	// Register state
	scc_cfg_t                 cfg_reg, cfg_next;
	logic signed [15:0]       ovr_reg, ovr_next;          // serial_speed_torque_override
	logic [SCC_IRQ_W-1:0]     stat_reg, stat_next;
	logic [SCC_IRQ_W-1:0]     mask_reg, mask_next;
	logic                     ack_reg, ack_next;          // Bus answer cycle
	logic [31:0]              rdata_reg, rdata_next;
	logic [1:0]               mode_reg, mode_next;        // Last seen control mode
	logic                     ana_reg, ana_next;          // Last analog enable
	// Datapath state
	logic signed [15:0]       vel_reg, vel_next;
	logic signed [15:0]       op_reg, op_next;
	logic [31:0]              pos_reg, pos_next;
	logic [1:0]               quad_reg, quad_next;
	logic                     fa_reg, fa_next, fb_reg, fb_next;
	scc_state_t               st_reg, st_next;
	logic [4:0]               mon;                        // Monitor word

	// Bus helpers
	logic        acc, wr_hit, halt_cmd, clear_ovr;
	logic        refuse;
	logic signed [16:0] wcmd;
	logic [SCC_IRQ_W-1:0] ev;
	logic signed [16:0] shaped;
	logic signed [16:0] ain, adz_ext, adz_mag;
	logic [23:0] err_mag;
	logic        send_now;

	// Waitrequest drops in the second cycle of every access
	assign acc             = (avs_read | avs_write) & ~ack_reg;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_hit          = avs_write & acc;
	assign avs_readdata    = rdata_reg;
	assign irq             = |(stat_reg & mask_reg);

	// Monitors are plain wires; debounce and polarity happen upstream
	assign mon = {driver_ok_output, in_operation_raw,
	              estop_input, jog_sense_input, alarm_clear_input};

	// Register file, stop handling and events
	always_comb begin
		cfg_next   = cfg_reg;
		ovr_next   = ovr_reg;
		mask_next  = mask_reg;
		rdata_next = rdata_reg;
		ack_next   = acc;
		mode_next  = ctrl_mode;
		halt_cmd   = 1'b0;
		refuse     = 1'b0;
		ev         = '0;
		wcmd       = {avs_writedata[15], avs_writedata[15:0]};
		if (wr_hit) begin
			case (avs_address)
				SCC_DEADZONE_OFS: begin
					cfg_next.adz = avs_writedata[SCC_ADZ_LSB +: 11];
					cfg_next.pdz = avs_writedata[SCC_PDZ_LSB +: 12];
				end
				SCC_CONFIG_OFS: begin
					cfg_next.sense  = avs_writedata[SCC_CFG_SENSE];
					cfg_next.phase  = avs_writedata[SCC_CFG_PHASE];
					cfg_next.notify = avs_writedata[SCC_CFG_NOTIFY];
					cfg_next.analog = avs_writedata[SCC_CFG_ANALOG];
				end
				SCC_OVERRIDE_OFS: begin
					// Analog input has the command path; refuse and flag it
					if (cfg_reg.analog) begin
						refuse = 1'b1;
					end else if (wcmd < SCC_CMD_MIN) begin
						ovr_next = SCC_CMD_MIN[15:0];
					end else begin
						ovr_next = avs_writedata[15:0];
					end
				end
				SCC_MASK_OFS: mask_next = avs_writedata[SCC_IRQ_W-1:0];
				SCC_HALTCMD_OFS: halt_cmd = avs_writedata[0]; // motion_halt_cmd
				default: begin
					// Status is handled below; others ignore writes
				end
			endcase
		end
		// Any stop condition forces the override back to zero
		clear_ovr = ~servo_on | estop_input | overtravel | halt_input | halt_cmd
		          | (ctrl_mode != mode_reg) | (cfg_next.analog & ~ana_reg);
		if (clear_ovr) begin
			ovr_next = SCC_OVR_RST;
		end
		ana_next = cfg_next.analog;
		ev[SCC_IRQ_INHIBIT] = refuse;
		ev[SCC_IRQ_CLEARED] = clear_ovr & (ovr_reg != SCC_OVR_RST);
		ev[SCC_IRQ_SENT]    = send_now;
		// Write-one clears, but a fresh event wins
		stat_next = stat_reg;
		if (wr_hit && avs_address == SCC_STATUS_OFS) begin
			stat_next = stat_reg & ~avs_writedata[SCC_IRQ_W-1:0];
		end
		stat_next = stat_next | ev;
		// Capture read data so it is stable when waitrequest falls
		if (avs_read & acc) begin
			case (avs_address)
				SCC_DEADZONE_OFS: rdata_next = {4'h0, cfg_reg.pdz, 5'h00, cfg_reg.adz};
				SCC_CONFIG_OFS:   rdata_next = {28'h0000000, cfg_reg.analog,
				                                cfg_reg.notify, cfg_reg.phase, cfg_reg.sense};
				SCC_OVERRIDE_OFS: rdata_next = {{16{ovr_reg[15]}}, ovr_reg};
				SCC_STATUS_OFS:   rdata_next = {29'h00000000, stat_reg};
				SCC_MASK_OFS:     rdata_next = {29'h00000000, mask_reg};
				SCC_MONITOR_OFS:  rdata_next = {27'h0000000, mon};
				SCC_POSITION_OFS: rdata_next = pos_reg;
				default:          rdata_next = 32'h00000000; // Unmapped reads zero
			endcase
		end
	end

	// Register the register-file group
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg   <= '{adz: SCC_ADZ_RST, pdz: SCC_PDZ_RST, sense: 1'b0,
			               phase: 1'b0, notify: 1'b0, analog: 1'b0};
			ovr_reg   <= SCC_OVR_RST;
			stat_reg  <= '0;
			mask_reg  <= SCC_MASK_RST;
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
			mode_reg  <= 2'h0;
			ana_reg   <= 1'b0;
		end else if (ce) begin
			cfg_reg   <= cfg_next;
			ovr_reg   <= ovr_next;
			stat_reg  <= stat_next;
			mask_reg  <= mask_next;
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
			mode_reg  <= mode_next;
			ana_reg   <= ana_next;
		end
	end

	// Analog shaping notes
	// Positive setting: a symmetric window around zero is forced to zero
	// The window edges themselves pass unchanged
	// Negative setting: the magnitude is pushed away from zero
	// Zero input stays zero, so a negative band never invents motion
	// Zero setting: the input passes straight through
	// Results beyond the command range saturate rather than wrap
	// The dead zone is compared in counts, so no divider is needed
	// Limitation: the setting cannot be finer than one ADC count
	//
	// Position loop notes
	// The error magnitude is compared against the band, end point included
	// The most negative error still has a magnitude larger than any band
	//
	// Scale and feedback notes
	// The sense bit flips only the counting direction of the scale
	// The feedback counter follows the motor, so limits and phase stay put
	// A change of phase order takes effect at the next edge, even at rest
	// Users who swap phase order while moving may see one odd edge
	//
	// Command shaping; the setting is used as a raw ADC count offset,
	// so one count is 10 V / 32767 with no multiplier needed
	always_comb begin
		ain     = {analog_in[15], analog_in};
		adz_ext = {{6{cfg_reg.adz[10]}}, cfg_reg.adz};
		adz_mag = -adz_ext;
		shaped  = ain;
		if (adz_ext > 17'sh00000) begin
			// Inside the band the command is forced to zero
			if (ain < adz_ext && ain > -adz_ext) begin
				shaped = 17'sh00000;
			end
		end else if (adz_ext < 17'sh00000) begin
			// Outside offset, with zero kept at zero
			if (ain > 17'sh00000) begin
				shaped = ain + adz_mag;
			end else if (ain < 17'sh00000) begin
				shaped = ain - adz_mag;
			end else begin
				shaped = 17'sh00000;
			end
		end
		// Saturate so an offset cannot wrap the sign
		if (shaped > SCC_CMD_MAX) begin
			shaped = SCC_CMD_MAX;
		end else if (shaped < SCC_CMD_MIN) begin
			shaped = SCC_CMD_MIN;
		end
		// Analog input selects the source, else the serial override
		op_next = cfg_reg.analog ? shaped[15:0] : ovr_reg;
		// Position loop dead band in half-pulse units
		err_mag = pos_err_half[23] ? 24'(-pos_err_half) : 24'(pos_err_half);
		vel_next = (err_mag <= {12'h000, cfg_reg.pdz}) ? 16'sh0000 : vel_cmd_in;
		// Scale counts with the sense bit; feedback phase does not
		pos_next  = pos_reg;
		quad_next = quad_reg;
		if (motor_step) begin
			pos_next  = (motor_cw ^ cfg_reg.sense) ? pos_reg + 32'h1 : pos_reg - 32'h1;
			quad_next = motor_cw ? quad_reg + 2'h1 : quad_reg - 2'h1;
		end
		// Phase A leads for clockwise unless the order bit swaps them
		fa_next = cfg_reg.phase ? quad_next[1] : (quad_next[1] ^ quad_next[0]);
		fb_next = cfg_reg.phase ? (quad_next[1] ^ quad_next[0]) : quad_next[1];
	end

	// Datapath registers
	// Every datapath output is registered, one cycle after its inputs
	// The clock enable holds them all, so a paused block keeps its outputs
	// Reset brings the scale and the feedback phase back to zero
	// Register the datapath group
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vel_reg  <= 16'sh0000;
			op_reg   <= 16'sh0000;
			pos_reg  <= 32'h00000000;
			quad_reg <= 2'h0;
			fa_reg   <= 1'b0;
			fb_reg   <= 1'b0;
		end else if (ce) begin
			vel_reg  <= vel_next;
			op_reg   <= op_next;
			pos_reg  <= pos_next;
			quad_reg <= quad_next;
			fa_reg   <= fa_next;
			fb_reg   <= fb_next;
		end
	end

	assign vel_cmd_out    = vel_reg;
	assign op_cmd_out     = op_reg;
	assign position_scale = pos_reg;
	assign fb_a           = fa_reg;
	assign fb_b           = fb_reg;
	assign tx_data        = SCC_READY_CHAR;       // Constant, never changes
	// Offer the character only between edited lines
	assign tx_valid       = (st_reg == SCC_SEND);
	assign send_now       = tx_valid & tx_ready;

	// Ready-character sender notes
	// Idle: waits for a motion-done pulse with notify enabled
	// Wait: the terminal is editing a line, so the character is held
	// Send: the character is offered until the terminal takes it
	// If editing starts again before the take, the offer is withdrawn
	// A motion-done pulse outside idle is ignored; one pulse, one character
	// Trade-off: a second completion while busy is lost, not queued
	// Limitation: the character is fixed; only its timing is controlled
	// The sent event is raised at the edge where the character is taken
	//
	// Ready-character sender
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			SCC_IDLE: begin
				if (motion_done && cfg_reg.notify) begin
					st_next = line_edit_busy ? SCC_WAIT : SCC_SEND;
				end
			end
			SCC_WAIT: begin
				// Hold while the terminal is mid-line
				if (!line_edit_busy) begin
					st_next = SCC_SEND;
				end
			end
			SCC_SEND: begin
				if (line_edit_busy && !tx_ready) begin
					st_next = SCC_WAIT;
				end else if (tx_ready) begin
					st_next = SCC_IDLE;
				end
			end
			default: st_next = SCC_IDLE;
		endcase
	end

	// Register the sender state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= SCC_IDLE;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end
endmodule // scc_top

// *** rtl/scc_pkg.sv ***
// What this block does
// - Positive analog dead zone zeroes small inputs
// - Negative dead zone offsets inputs away from zero
// - Zero dead zone passes input; reset zero
// - Setting scales ten volts over 32767
// - Small position error zeroes velocity command
// - Serial override used in speed/torque modes
// - Override refused while analog enabled, inhibit reported
// - Stop conditions clear the serial override
// - Scale counting direction follows its setting
// - Scale sense leaves limits and feedback alone
// - Ready character 0x21 sent when enabled
// - Ready character waits for line editing
// - Feedback phase order follows its setting
// - Input monitors show debounced, polarity-corrected state
// - Output monitors show raw output state
package scc_pkg;
	// Register byte offsets
	localparam logic [7:0]  SCC_DEADZONE_OFS = 8'h00;
	localparam logic [7:0]  SCC_CONFIG_OFS   = 8'h04;
	localparam logic [7:0]  SCC_OVERRIDE_OFS = 8'h08;
	localparam logic [7:0]  SCC_STATUS_OFS   = 8'h0c;
	localparam logic [7:0]  SCC_MASK_OFS     = 8'h10;
	localparam logic [7:0]  SCC_MONITOR_OFS  = 8'h14;
	localparam logic [7:0]  SCC_HALTCMD_OFS  = 8'h18;
	localparam logic [7:0]  SCC_POSITION_OFS = 8'h1c;
	// Field positions
	localparam int SCC_ADZ_LSB     = 0;   // Analog dead zone [10:0]
	localparam int SCC_PDZ_LSB     = 16;  // Position dead zone [27:16]
	localparam int SCC_CFG_SENSE   = 0;
	localparam int SCC_CFG_PHASE   = 1;
	localparam int SCC_CFG_NOTIFY  = 2;
	localparam int SCC_CFG_ANALOG  = 3;
	localparam int SCC_IRQ_INHIBIT = 0;   // Override refused
	localparam int SCC_IRQ_SENT    = 1;   // Ready character sent
	localparam int SCC_IRQ_CLEARED = 2;   // Override cleared by a stop
	localparam int SCC_IRQ_W       = 3;
	// Reset values
	localparam logic signed [10:0] SCC_ADZ_RST = 11'sh000;
	localparam logic [11:0]        SCC_PDZ_RST = 12'h000;
	localparam logic signed [15:0] SCC_OVR_RST = 16'sh0000;
	localparam logic [SCC_IRQ_W-1:0] SCC_MASK_RST = 3'h0;
	// Command limits and the ready character
	localparam logic signed [16:0] SCC_CMD_MAX = 17'sh07fff;
	localparam logic signed [16:0] SCC_CMD_MIN = -17'sh07fff;
	localparam logic [7:0]         SCC_READY_CHAR = 8'h21;
	// Control settings carried together
	typedef struct packed {
		logic signed [10:0] adz;     // analog_cmd_deadzone, counts
		logic [11:0]        pdz;     // position_error_deadzone, half pulses
		logic               sense;   // scale_count_sense
		logic               phase;   // feedback_phase_order
		logic               notify;  // notify_ready_char
		logic               analog;  // analog_cmd_enable
	} scc_cfg_t;
	// Ready-character sender states, Gray only on the IDLE-WAIT and WAIT-SEND steps
	typedef enum logic [1:0] {
		SCC_IDLE = 2'b00,
		SCC_WAIT = 2'b01,
		SCC_SEND = 2'b11
	} scc_state_t;
endpackage

// *** dv/scc_host.sv ***
`timescale 1ns/100ps
// Serial terminal model: takes the ready character after a chosen wait
module scc_host (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic [3:0] delay,
	output logic            tx_ready,
	output int              rx_count,
	output logic [7:0]      rx_char
);
	logic [3:0] wait_cnt;  // Cycles the offer has stood
	// Ready is a one-cycle pulse, so a withdrawn offer is never taken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 4'h0;
			tx_ready <= 1'b0;
			rx_count <= 0;
			rx_char  <= 8'h00;
		end else begin
			tx_ready <= tx_valid && !tx_ready && (wait_cnt >= delay);
			wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 4'h1 : 4'h0;
			// Character taken only when offered and ready at one edge
			if (tx_valid && tx_ready) begin
				rx_count <= rx_count + 1;
				rx_char  <= tx_data;
			end
		end
	end
endmodule // scc_host

// *** dv/scc_chk.sv ***
`timescale 1ns/100ps
module scc_chk (
	input wire logic               sys_clk,
	input wire logic               rst_n,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic               avs_waitrequest,
	input wire logic               tx_valid,
	input wire logic               tx_ready,
	input wire logic [7:0]         tx_data,
	input wire logic               line_edit_busy,
	input wire logic signed [23:0] pos_err_half,
	input wire logic signed [15:0] vel_cmd_out,
	input wire logic               motor_step,
	input wire logic [31:0]        position_scale,
	input wire logic               fb_a,
	input wire logic               fb_b
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	chk_wr_one_wait: assert property (
		$rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("write wait");
	chk_rd_one_wait: assert property (
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
	chk_ready_char: assert property (tx_valid |-> tx_data == 8'h21)
		else $error("bad ready char");
	chk_offer_stands: assert property (
		tx_valid && !tx_ready && !line_edit_busy |=> tx_valid) else $error("offer dropped");
	chk_offer_taken: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("char sent twice");
	chk_edit_holds: assert property (line_edit_busy [*2] |-> !tx_valid)
		else $error("char during edit");
	chk_err_zero: assert property (pos_err_half == 24'sh0 |=> vel_cmd_out == 16'sh0)
		else $error("velocity not zeroed");
	chk_scale_step: assert property (motor_step |=>
		(position_scale - $past(position_scale)) inside {32'h1, 32'hffffffff})
		else $error("scale step");
	chk_scale_hold: assert property (!motor_step |=> $stable(position_scale))
		else $error("scale moved");
	chk_fb_one_edge: assert property (motor_step && !avs_write |=>
		$countones({fb_a, fb_b} ^ $past({fb_a, fb_b})) == 1) else $error("feedback edge");
endmodule // scc_chk
bind scc_top scc_chk u_chk (.sys_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
	.tx_valid, .tx_ready, .tx_data, .line_edit_busy, .pos_err_half, .vel_cmd_out,
	.motor_step, .position_scale, .fb_a, .fb_b);

// *** dv/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import scc_pkg::*;
	typedef struct packed {
		logic [10:0] adz;
		logic [15:0] ain;
		logic [15:0] exp;
	} scc_row_t;
	logic               sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
	logic [7:0]         avs_address = 0, tx_data, rx_char;
	logic [31:0]        avs_writedata = 0, avs_readdata, position_scale, rd;
	logic               avs_waitrequest, irq, tx_valid, tx_ready, fb_a, fb_b;
	logic signed [15:0] analog_in = 0, vel_cmd_in = 16'sh0777, vel_cmd_out, op_cmd_out;
	logic signed [23:0] pos_err_half = 0;
	logic [1:0]         ctrl_mode = 0;
	logic               servo_on = 1, overtravel = 0, halt_input = 0, ce = 1;
	logic               motor_step = 0, motor_cw = 0, motion_done = 0, line_edit_busy = 0;
	logic [4:0]         mon = 0;    // Monitored inputs, low bit first
	logic [3:0]         delay = 0;  // Terminal answer delay
	int                 rx_count, n_mismatch = 0, checked = 0, i;
	// Analog shaping cases: setting, input, expected command
	scc_row_t rows [11] = '{'{11'h064, 16'h0032, 16'h0000}, '{11'h064, 16'hff9d, 16'h0000},
		'{11'h064, 16'h0064, 16'h0064}, '{11'h064, 16'hff6a, 16'hff6a},
		'{11'h79c, 16'h0000, 16'h0000}, '{11'h79c, 16'h0005, 16'h0069},
		'{11'h79c, 16'hfffb, 16'hff97}, '{11'h79c, 16'h7fbc, 16'h7fff},
		'{11'h000, 16'hfb2e, 16'hfb2e}, '{11'h3ff, 16'h03fe, 16'h0000},
		'{11'h3ff, 16'hfc01, 16'hfc01}};
	scc_top dut (.sys_clk, .rst_n, .ce, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq,
		.analog_in, .pos_err_half, .vel_cmd_in, .ctrl_mode, .vel_cmd_out, .op_cmd_out,
		.servo_on, .overtravel, .halt_input, .motor_step, .motor_cw, .position_scale,
		.fb_a, .fb_b, .motion_done, .line_edit_busy, .tx_ready, .tx_valid, .tx_data,
		.alarm_clear_input(mon[0]), .jog_sense_input(mon[1]), .estop_input(mon[2]),
		.in_operation_raw(mon[3]), .driver_ok_output(mon[4]));
	scc_host host (.sys_clk, .rst_n, .tx_valid, .tx_data, .delay, .tx_ready, .rx_count,
		.rx_char);
	initial forever #5 sys_clk = ~sys_clk;
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus access; held until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge sys_clk);
		end
		if (n >= 20) n_mismatch++;
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Gap before the step keeps config writes off the feedback edge
	task step(input logic cw);
		tick(3);
		motor_cw <= cw;
		motor_step <= 1'b1;
		tick(1);
		motor_step <= 1'b0;
		tick(2);
	endtask
	task final_report;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		tick(6);
		rst_n <= 1'b1;
		bus(0, SCC_DEADZONE_OFS, 0); chk("deadzone", rd, 0);
		bus(0, SCC_CONFIG_OFS, 0); chk("config", rd, 0);
		bus(0, SCC_OVERRIDE_OFS, 0); chk("override", rd, 0);
		bus(0, 8'h20, 0); chk("unmapped", rd, 0);
		$display("reset test done");
		bus(1, SCC_CONFIG_OFS, 32'h8);
		foreach (rows[k]) begin
			bus(1, SCC_DEADZONE_OFS, {21'h0, rows[k].adz});
			analog_in <= rows[k].ain;
			tick(3);
			chk("op_cmd", op_cmd_out[15:0], rows[k].exp);
		end
		$display("analog test done");
		// Override while analog is on is refused and flagged
		bus(1, SCC_MASK_OFS, 32'h7);
		bus(1, SCC_OVERRIDE_OFS, 32'h5);
		bus(0, SCC_OVERRIDE_OFS, 0); chk("refused", rd, 0);
		chk("irq", irq, 1);
		bus(1, SCC_CONFIG_OFS, 0);
		// Each stop source in turn clears a standing override
		for (i = 0; i < 6; i++) begin
			bus(1, SCC_OVERRIDE_OFS, 32'hffff8001);
			tick(2);
			chk("override", op_cmd_out[15:0], 16'h8001);
			case (i)
				0: servo_on <= 1'b0;
				1: mon[2] <= 1'b1;
				2: overtravel <= 1'b1;
				3: halt_input <= 1'b1;
				4: ctrl_mode <= ~ctrl_mode;
				default: bus(1, SCC_HALTCMD_OFS, 32'h1);
			endcase
			tick(1);
			servo_on <= 1'b1;
			mon[2] <= 1'b0;
			overtravel <= 1'b0;
			halt_input <= 1'b0;
			bus(0, SCC_OVERRIDE_OFS, 0); chk("cleared", rd, 0);
		end
		bus(0, SCC_STATUS_OFS, 0); chk("status", rd, 32'h5);
		bus(1, SCC_STATUS_OFS, 32'h7);
		tick(2);
		chk("irq clear", irq, 0);
		$display("override test done");
		// Scale follows sense, feedback follows the motor and phase order only
		bus(1, SCC_CONFIG_OFS, 32'h1);
		step(1);
		chk("scale", position_scale, 32'hffffffff);
		chk("fb", {fb_a, fb_b}, 2'b10);
		bus(1, SCC_CONFIG_OFS, 32'h0);
		step(1);
		chk("scale", position_scale, 0);
		bus(1, SCC_CONFIG_OFS, 32'h2);
		step(1);
		chk("fb", {fb_a, fb_b}, 2'b10);
		bus(0, SCC_POSITION_OFS, 0); chk("position", rd, 32'h1);
		$display("scale test done");
		// Ready character held during editing, slow terminal
		bus(1, SCC_CONFIG_OFS, 32'h4);
		delay <= 4'h3;
		line_edit_busy <= 1'b1;
		tick(1);
		motion_done <= 1'b1;
		tick(1);
		motion_done <= 1'b0;
		tick(10);
		chk("held", rx_count, 0);
		line_edit_busy <= 1'b0;
		tick(12);
		chk("sent", rx_count, 1);
		chk("char", rx_char, 8'h21);
		chk("irq sent", irq, 1);
		bus(1, SCC_CONFIG_OFS, 0);
		motion_done <= 1'b1;
		tick(1);
		motion_done <= 1'b0;
		tick(10);
		chk("silent", rx_count, 1);
		$display("ready char test done");
		for (i = 0; i < 5; i++) begin
			mon <= 5'h1 << i;
			tick(2);
			bus(0, SCC_MONITOR_OFS, 0); chk("monitor", rd, 32'h1 << i);
		end
		mon <= 5'h0;
		// Position error at and past the dead zone edge
		bus(1, SCC_DEADZONE_OFS, 32'h000a0000);
		pos_err_half <= 24'sd10;
		tick(3);
		chk("vel", vel_cmd_out[15:0], 0);
		pos_err_half <= -24'sd11;
		tick(3);
		chk("vel", vel_cmd_out[15:0], 16'h0777);
		// Clock enable low freezes the registered command
		ce <= 1'b0;
		pos_err_half <= 24'sd5;
		tick(3);
		chk("vel frozen", vel_cmd_out[15:0], 16'h0777);
		ce <= 1'b1;
		tick(3);
		chk("vel run", vel_cmd_out[15:0], 0);
		$display("monitor and dead zone test done");
		final_report;
	end
	initial begin
		tick(20000);
		n_mismatch++;
		final_report;
	end
endmodule // testbench
